// *** logic/tppc_pkg.sv ***
//////////////////////////////////////////////////////////////////////////////
// Contract
// R1 - One ten-bit counter; frequency and duty set by programmed ten-bit values.
// R2 - Three duty values, one per channel, each from low and high parts.
// R3 - Period assembled from low and high parts into one ten-bit value.
// R4 - Read-only register pair returns the live counter value.
// R5 - Run bit starts counter; clearing it halts counting and turns outputs off.
// R6 - Two-bit clock select picks which divided clock advances the counter.
// R7 - Two-bit alignment field picks edge or center aligned counting.
// R8 - Duty and period registers are write-only; reads return zero.
// R9 - Broadcast bit copies channel-0 duty writes into channels 1 and 2.
// R10 - Sync-update enable makes the three duty values take effect together.
// R11 - With sync enabled, request flag applies all duties then self-clears.
// R12 - Six gate outputs are channel 0,1,2 high and low, A top first.
// R13 - High part write fills a two-bit buffer; low write commits both.
// R14 - Alignment codes 00 and 01 edge, 10 center one, 11 center two. The code runs 10 and 11 as the same center mode.
// R15 - Clock select codes divide the generator clock by 1, 2, 4 or 8.
// R16 - Load bit loads period after next underflow; hardware clears it next cycle.
// R17 - Channel active while counter is below its effective duty value.
// R18 - Center counts up to period and back; edge reloads at period end.
//////////////////////////////////////////////////////////////////////////////
package tppc_pkg;
  localparam int          CNT_W       = 10;
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 8;
  localparam int          HI_W        = 2;
  // Register offsets
  localparam logic [3:0]  A_GEN_CTRL  = 4'h0;
  localparam logic [3:0]  A_SYNC_CTRL = 4'h1;
  localparam logic [3:0]  A_DUTY0_LO  = 4'h2;
  localparam logic [3:0]  A_DUTY0_HI  = 4'h3;
  localparam logic [3:0]  A_DUTY1_LO  = 4'h4;
  localparam logic [3:0]  A_DUTY1_HI  = 4'h5;
  localparam logic [3:0]  A_DUTY2_LO  = 4'h6;
  localparam logic [3:0]  A_DUTY2_HI  = 4'h7;
  localparam logic [3:0]  A_PER_LO    = 4'h8;
  localparam logic [3:0]  A_PER_HI    = 4'h9;
  localparam logic [3:0]  A_CNT_LO    = 4'hA;
  localparam logic [3:0]  A_CNT_HI    = 4'hB;
  // Generator control fields
  localparam int          B_ALIGN     = 6;
  localparam int          B_CKSEL     = 4;
  localparam int          B_RUN       = 3;
  localparam int          B_ITC       = 1;
  localparam int          B_LOAD      = 0;
  // Sync control fields
  localparam int          B_REQ       = 2;
  localparam int          B_SYNC      = 1;
  localparam int          B_BCAST     = 0;
  localparam logic [1:0]  ALIGN_CTR1  = 2'h2;
  localparam logic [1:0]  ALIGN_CTR2  = 2'h3;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [9:0]  VAL_RST     = 10'h000;
endpackage : tppc_pkg

// *** logic/tppc_three_phase_pwm.sv ***
`timescale 1ns/1ns
module tppc_three_phase_pwm #(
  parameter int CNT_W = tppc_pkg::CNT_W
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic      [7:0]  regRdData,
  output logic             phaseATopGate,
  output logic             phaseABottomGate,
  output logic             phaseBTopGate,
  output logic             phaseBBottomGate,
  output logic             phaseCTopGate,
  output logic             phaseCBottomGate
);
  typedef enum logic [0:0] {TPPC_UP = 1'b0, TPPC_DOWN = 1'b1} tppc_dir_t;

  logic [7:0]       genCtrl_ff;
  logic [2:0]       syncCtrl_ff;
  logic [1:0]       hiBuf_ff;
  logic [CNT_W-1:0] dutyWr_ff [3];
  logic [CNT_W-1:0] dutyAct_ff [3];
  logic [CNT_W-1:0] period_ff;
  logic [CNT_W-1:0] periodAct_ff;
  logic [CNT_W-1:0] count_ff;
  tppc_dir_t        dir_ff;
  logic [2:0]       div_ff;
  logic             underflow_ff;

  logic             run;
  logic             tick;
  logic             center;
  logic [1:0]       ckSel;

  assign run    = genCtrl_ff[tppc_pkg::B_RUN];
  assign ckSel  = genCtrl_ff[tppc_pkg::B_CKSEL+:2];
  assign center = genCtrl_ff[tppc_pkg::B_ALIGN+1]; // R14

  function automatic logic isWr(input logic [3:0] a);
    isWr = regWrStb && (regAddr == a);
  endfunction : isWr

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      genCtrl_ff <= tppc_pkg::CTRL_RST;
    end else if (isWr(tppc_pkg::A_GEN_CTRL)) begin
      genCtrl_ff <= regWrData;
    end else if (genCtrl_ff[tppc_pkg::B_LOAD] && underflow_ff) begin
      genCtrl_ff[tppc_pkg::B_LOAD] <= 1'b0; // R16
    end
  end

  // Request flag: software set wins over the hardware clear in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncCtrl_ff <= 3'h0;
    end else if (isWr(tppc_pkg::A_SYNC_CTRL)) begin
      syncCtrl_ff <= regWrData[2:0];
    end else if (syncCtrl_ff[tppc_pkg::B_REQ]) begin
      syncCtrl_ff[tppc_pkg::B_REQ] <= 1'b0; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty and period write path
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hiBuf_ff <= 2'h0;
    end else if (regWrStb && (regAddr == tppc_pkg::A_DUTY0_HI || regAddr == tppc_pkg::A_DUTY1_HI ||
                 regAddr == tppc_pkg::A_DUTY2_HI || regAddr == tppc_pkg::A_PER_HI)) begin
      hiBuf_ff <= regWrData[1:0]; // R13
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 3; i++) begin
        dutyWr_ff[i] <= tppc_pkg::VAL_RST;
      end
      period_ff <= tppc_pkg::VAL_RST;
    end else begin
      if (isWr(tppc_pkg::A_DUTY0_LO)) begin
        dutyWr_ff[0] <= {hiBuf_ff, regWrData}; // R2 R13
        if (syncCtrl_ff[tppc_pkg::B_BCAST]) begin
          dutyWr_ff[1] <= {hiBuf_ff, regWrData}; // R9
          dutyWr_ff[2] <= {hiBuf_ff, regWrData}; // R9
        end
      end
      if (isWr(tppc_pkg::A_DUTY1_LO)) begin
        dutyWr_ff[1] <= {hiBuf_ff, regWrData};
      end
      if (isWr(tppc_pkg::A_DUTY2_LO)) begin
        dutyWr_ff[2] <= {hiBuf_ff, regWrData};
      end
      if (isWr(tppc_pkg::A_PER_LO)) begin
        period_ff <= {hiBuf_ff, regWrData}; // R3 R13
      end
    end
  end

  // Without sync mode the comparators track writes directly; with it they
  // wait for the request so all three phases change in one cycle.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 3; i++) begin
        dutyAct_ff[i] <= tppc_pkg::VAL_RST;
      end
    end else if (!syncCtrl_ff[tppc_pkg::B_SYNC] || syncCtrl_ff[tppc_pkg::B_REQ]) begin
      for (int i = 0; i < 3; i++) begin
        dutyAct_ff[i] <= dutyWr_ff[i]; // R10 R11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_ff <= 3'h0;
    end else if (!run) begin
      div_ff <= 3'h0;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end

  always_comb begin
    case (ckSel) // R15 R6
      2'h0:    tick = run;
      2'h1:    tick = run && (div_ff[0] == 1'b1);
      2'h2:    tick = run && (div_ff[1:0] == 2'h3);
      default: tick = run && (div_ff == 3'h7);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  // Period becomes active at underflow; with load bit clear it is taken at
  // every underflow so the block works even if software never sets it.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      periodAct_ff <= tppc_pkg::VAL_RST;
    end else if (underflow_ff || !run) begin
      periodAct_ff <= period_ff; // R16 R1
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_ff     <= tppc_pkg::VAL_RST;
      dir_ff       <= TPPC_UP;
      underflow_ff <= 1'b0;
    end else if (!run) begin
      count_ff     <= tppc_pkg::VAL_RST; // R5
      dir_ff       <= TPPC_UP;
      underflow_ff <= 1'b0;
    end else begin
      underflow_ff <= 1'b0;
      if (tick) begin
        if (!center) begin // R7 R18
          if (count_ff >= periodAct_ff) begin
            count_ff     <= tppc_pkg::VAL_RST;
            underflow_ff <= 1'b1;
          end else begin
            count_ff <= count_ff + 1'b1;
          end
        end else if (dir_ff == TPPC_UP) begin // R18
          if (count_ff >= periodAct_ff) begin
            dir_ff   <= TPPC_DOWN;
            count_ff <= (count_ff == '0) ? count_ff : count_ff - 1'b1;
          end else begin
            count_ff <= count_ff + 1'b1;
          end
        end else begin
          if (count_ff == '0) begin
            dir_ff       <= TPPC_UP;
            underflow_ff <= 1'b1;
          end else begin
            count_ff <= count_ff - 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: high side is the PWM, low side its complement; dead time is
  // downstream, so both are forced off while stopped.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phaseATopGate    <= 1'b0;
      phaseABottomGate <= 1'b0;
      phaseBTopGate    <= 1'b0;
      phaseBBottomGate <= 1'b0;
      phaseCTopGate    <= 1'b0;
      phaseCBottomGate <= 1'b0;
    end else begin
      phaseATopGate    <= run && (count_ff < dutyAct_ff[0]); // R17 R12
      phaseABottomGate <= run && !(count_ff < dutyAct_ff[0]); // R12
      phaseBTopGate    <= run && (count_ff < dutyAct_ff[1]); // R17
      phaseBBottomGate <= run && !(count_ff < dutyAct_ff[1]);
      phaseCTopGate    <= run && (count_ff < dutyAct_ff[2]); // R17
      phaseCBottomGate <= run && !(count_ff < dutyAct_ff[2]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 8'h00;
    end else if (!regRdStb) begin
      regRdData <= 8'h00;
    end else if (regAddr == tppc_pkg::A_GEN_CTRL) begin
      regRdData <= genCtrl_ff;
    end else if (regAddr == tppc_pkg::A_SYNC_CTRL) begin
      regRdData <= {5'h00, syncCtrl_ff};
    end else if (regAddr == tppc_pkg::A_CNT_LO) begin
      regRdData <= count_ff[7:0]; // R4
    end else if (regAddr == tppc_pkg::A_CNT_HI) begin
      regRdData <= {6'h00, count_ff[CNT_W-1:8]}; // R4
    end else begin
      regRdData <= 8'h00; // R8
    end
  end
endmodule : tppc_three_phase_pwm

// *** sim/tppc_three_phase_pwm_properties.sv ***
`timescale 1ns/1ns
module tppc_three_phase_pwm_properties #(
  parameter int CNT_W = 10
) (
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrStb,
  input wire logic       regRdStb,
  input wire logic [7:0] regRdData,
  input wire logic       phaseATopGate,
  input wire logic       phaseABottomGate,
  input wire logic       phaseBTopGate,
  input wire logic       phaseBBottomGate,
  input wire logic       phaseCTopGate,
  input wire logic       phaseCBottomGate
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic       runOn_ff;
  logic [2:0] tops;
  logic [2:0] bots;
  assign tops = {phaseCTopGate, phaseBTopGate, phaseATopGate};
  assign bots = {phaseCBottomGate, phaseBBottomGate, phaseABottomGate};
  // The run bit is not a port, so mirror it from the write traffic
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      runOn_ff <= 1'b0;
    else if (regWrStb && regAddr == tppc_pkg::A_GEN_CTRL)
      runOn_ff <= regWrData[tppc_pkg::B_RUN];
  end
  ////////////////////////////////////////////////////////////////////////
  a_read_idle_zero: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
    else $error("read data not zero outside a read answer");
  a_write_only_hidden: assert property ($past(regRdStb) && $past(regAddr) inside {[4'h2:4'h9]}
    |-> regRdData == 8'h00) else $error("write-only register returned data");
  a_unmapped_read_zero: assert property ($past(regRdStb) && $past(regAddr) > 4'hB
    |-> regRdData == 8'h00) else $error("unmapped register returned data");
  a_count_high_width: assert property ($past(regRdStb) && $past(regAddr) == tppc_pkg::A_CNT_HI
    |-> regRdData[7:2] == 6'h00) else $error("counter high part wider than two bits");
  a_sync_unused_bits: assert property ($past(regRdStb) && $past(regAddr) == tppc_pkg::A_SYNC_CTRL
    |-> regRdData[7:3] == 5'h00) else $error("sync control unused bits set");
  a_stop_gates_off: assert property (!runOn_ff && !$past(runOn_ff) |-> {tops, bots} == 6'h00)
    else $error("gate active while stopped");
  a_stop_count_zero: assert property (!runOn_ff && !$past(runOn_ff) && !$past(runOn_ff, 2)
    && !$past(runOn_ff, 3) && $past(regRdStb) && $past(regAddr) == tppc_pkg::A_CNT_LO
    |-> regRdData == 8'h00) else $error("counter not zero while stopped");
  a_run_complement: assert property (runOn_ff && $past(runOn_ff) |-> bots == ~tops)
    else $error("bottom gate not complement of top gate");
endmodule : tppc_three_phase_pwm_properties

bind tppc_three_phase_pwm tppc_three_phase_pwm_properties #(.CNT_W(CNT_W)) tppc_three_phase_pwm_properties_i (
  .sys_clk, .arst_n, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .phaseATopGate,
  .phaseABottomGate, .phaseBTopGate, .phaseBBottomGate, .phaseCTopGate, .phaseCBottomGate);

// *** sim/tppc_gate_sink.sv ***
`timescale 1ns/1ns
// Stands in for the mask and dead-time stage: tallies top-arm on time per phase
module tppc_gate_sink (
  input  wire logic        sys_clk,
  input  wire logic        clear,
  input  wire logic [2:0]  topGate,
  input  wire logic [2:0]  bottomGate,
  output logic      [15:0] onCnt [3],
  output logic             overlapSeen
);
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      onCnt[i] <= clear ? 16'h0000 : onCnt[i] + 16'(topGate[i]);
    end
    // Both arms on would short the supply downstream
    overlapSeen <= clear ? 1'b0 : (overlapSeen | (|(topGate & bottomGate)));
  end
endmodule : tppc_gate_sink

// *** sim/tppc_three_phase_pwm_tb.sv ***
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin mismatches++; \
  $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module tppc_three_phase_pwm_tb;
  localparam logic [9:0] PER = 10'h014;
  logic        sys_clk   = 1'b0;
  logic        arst_n    = 1'b0;
  logic [3:0]  regAddr   = 4'h0;
  logic [7:0]  regWrData = 8'h00;
  logic        regWrStb  = 1'b0;
  logic        regRdStb  = 1'b0;
  logic        clear     = 1'b1;
  logic [7:0]  regRdData;
  logic [7:0]  rdv;
  logic [2:0]  top;
  logic [2:0]  bot;
  logic [15:0] onCnt [3];
  logic        overlapSeen;
  int          mismatches     = 0;
  int          samplesChecked = 0;
  int          cycles         = 0;
  int          len;
  int          on;
  always #10 sys_clk = ~sys_clk;
  tppc_three_phase_pwm tppc_three_phase_pwm_i (.sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .phaseATopGate(top[0]), .phaseABottomGate(bot[0]), .phaseBTopGate(top[1]),
    .phaseBBottomGate(bot[1]), .phaseCTopGate(top[2]), .phaseCBottomGate(bot[2]));
  tppc_gate_sink tppc_gate_sink_i (.sys_clk(sys_clk), .clear(clear), .topGate(top), .bottomGate(bot),
    .onCnt(onCnt), .overlapSeen(overlapSeen));
  ////////////////////////////////////////////////////////////////////////
  task automatic giveVerdict();
    $display("checked %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : giveVerdict
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1;
    rdv = regRdData;
  endtask : rd
  task automatic chkRd(input logic [3:0] a, input logic [7:0] ex, input string nm);
    rd(a);
    `CHK(nm, ex, rdv)
  endtask : chkRd
  // High part only fills the holding buffer, so it must go first
  task automatic wr10(input logic [3:0] hi, input logic [9:0] v);
    wr(hi, {6'h00, v[9:8]});
    wr(hi - 4'h1, v[7:0]);
  endtask : wr10
  task automatic measure(input int n, input int e0, input int e1, input int e2);
    @(posedge sys_clk);
    clear <= 1'b1;
    @(posedge sys_clk);
    clear <= 1'b0;
    repeat (n) @(posedge sys_clk);
    #1;
    `CHK("onCnt0", e0, onCnt[0])
    `CHK("onCnt1", e1, onCnt[1])
    `CHK("onCnt2", e2, onCnt[2])
    `CHK("overlap", 1'b0, overlapSeen)
  endtask : measure
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      giveVerdict();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    chkRd(tppc_pkg::A_GEN_CTRL, 8'h00, "genCtrl");
    chkRd(tppc_pkg::A_CNT_HI, 8'h00, "cntHi");
    wr10(tppc_pkg::A_PER_HI, PER);
    wr(tppc_pkg::A_SYNC_CTRL, 8'h01);
    wr10(tppc_pkg::A_DUTY0_HI, 10'h005);
    for (int a = 2; a < 16; a++) begin
      if (a < 10 || a > 11) chkRd(4'(a), 8'h00, "hiddenReg");
    end
    $display("test registers done");
    // Align and clock select stepped together: every code of both fields is used
    for (int m = 0; m < 4; m++) begin
      wr(tppc_pkg::A_GEN_CTRL, 8'(m * 8'h50 + 8'h08));
      repeat (400) @(posedge sys_clk);
      // Center mode holds zero once going down and once going up: 2 * PER + 1 states
      len = (m < 2 ? PER + 1 : 2 * PER + 1) * (1 << m);
      on = (m < 2 ? 5 : 10) * (1 << m);
      measure(3 * len, 3 * on, 3 * on, 3 * on);
    end
    chkRd(tppc_pkg::A_CNT_HI, 8'h00, "cntHiRange");
    rd(tppc_pkg::A_CNT_LO);
    `CHK("cntLoLive", 1'b1, rdv <= PER[7:0])
    $display("test modes done");
    wr(tppc_pkg::A_GEN_CTRL, 8'h08);
    wr(tppc_pkg::A_SYNC_CTRL, 8'h02);
    wr10(tppc_pkg::A_DUTY1_HI, 10'h00A);
    wr10(tppc_pkg::A_DUTY2_HI, 10'h00F);
    measure(3 * (PER + 1), 15, 15, 15);
    wr(tppc_pkg::A_SYNC_CTRL, 8'h06);
    chkRd(tppc_pkg::A_SYNC_CTRL, 8'h02, "syncReq");
    measure(3 * (PER + 1), 15, 30, 45);
    $display("test sync done");
    wr(tppc_pkg::A_GEN_CTRL, 8'h09);
    repeat (2 * (PER + 1)) @(posedge sys_clk);
    chkRd(tppc_pkg::A_GEN_CTRL, 8'h08, "loadBit");
    wr(tppc_pkg::A_GEN_CTRL, 8'h00);
    repeat (4) @(posedge sys_clk);
    chkRd(tppc_pkg::A_CNT_LO, 8'h00, "cntStopped");
    measure(50, 0, 0, 0);
    $display("test load and stop done");
    giveVerdict();
  end
endmodule : tppc_three_phase_pwm_tb
